// ### tics_pkg.sv
// shared types and constants for the transmit input clock select block
package tics_pkg;

	// three-level static select: an undriven pin self-biases to the middle level
	typedef struct packed {
		logic driven; // pin is pulled hard to a rail
		logic high; // rail level when driven
	} tics_tri_t;

	typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH} tics_level_t;

	// how a captured character is interpreted downstream
	typedef enum logic [1:0] {KIND_DATA, KIND_SPECIAL, KIND_REPLACE, KIND_WORD_SYNC} tics_kind_t;

	// one captured transmit character with its side bits
	typedef struct packed {
		logic [7:0] tx_char_bus;
		logic [1:0] tx_control_bits;
		logic parity;
		logic special_char_select;
	} tics_word_t;

	localparam int LANE_PIPE_DEPTH = 4; // phase taps of a lane capture path
	localparam logic [4:0] PLL_MULT_LOW = 5'h0A; // multiplier with rate select low
	localparam logic [4:0] PLL_MULT_HIGH = 5'h14; // multiplier with rate select high
	localparam logic [1:0] TXCLK_HALF_LOW = 2'h2; // cycles per half period, rate low
	localparam logic [1:0] TXCLK_HALF_HIGH = 2'h1; // cycles per half period, rate high

	localparam logic [7:0] ADDR_CTRL = 8'h00; // control register byte address
	localparam logic [7:0] ADDR_STATUS = 8'h04; // status register byte address
	localparam int CTRL_PHASE_ADJ_BIT = 0; // forces phase adjustment while set
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam int STAT_INVALID_BIT = 0; // invalid clock configuration
	localparam int STAT_PAR_A_BIT = 1; // sticky parity error, lane a
	localparam int STAT_PAR_B_BIT = 2; // sticky parity error, lane b
	localparam int STAT_MULT_LSB = 3; // pll multiplier field, five bits
	localparam int STAT_ADJ_BIT = 8; // phase adjustment in progress

	// resolve a three-level pin, floating reads as middle
	function automatic tics_level_t tics_level(input tics_tri_t pin);
		if (!pin.driven) begin
			return TRI_MID;
		end
		return pin.high ? TRI_HIGH : TRI_LOW;
	endfunction

	// special select plus control bits pick the character interpretation
	function automatic tics_kind_t tics_kind(input tics_word_t w);
		if (w.special_char_select && (w.tx_control_bits == 2'h3)) begin
			return KIND_WORD_SYNC;
		end
		if (w.tx_control_bits[0]) begin
			return KIND_SPECIAL;
		end
		return w.tx_control_bits[1] ? KIND_REPLACE : KIND_DATA;
	endfunction

	// odd parity holds when data and parity together xor to one
	function automatic logic tics_parity_bad(input tics_word_t w);
		return ~(^{w.tx_char_bus, w.parity});
	endfunction

endpackage

// ### tics_lane_capture.sv
// one lane capture path on a lane input clock, with adjustable capture phase
`timescale 1ns/10ps
module tics_lane_capture (
	input wire logic lane_input_clock,
	input wire logic srst,
	input wire logic adjust_req,
	input wire tics_pkg::tics_word_t word_in,
	output tics_pkg::tics_word_t word_out,
	output logic toggle_out,
	output logic adjusting
);
	import tics_pkg::*;

	// all lane-domain state
	typedef struct packed {
		logic rst_s1; // reset synchroniser, first stage
		logic rst_s2; // reset synchroniser, second stage
		logic adj_s1; // adjust request, first stage
		logic adj_s2; // adjust request, second stage
		logic [1:0] phase; // selected capture tap
		tics_word_t [LANE_PIPE_DEPTH-1:0] pipe; // tapped capture line
		tics_word_t word; // word offered to the reference side
		logic toggle; // flips once per offered word
	} tics_lane_t;

	tics_lane_t st;
	tics_lane_t next_st;

	// next-state logic; reset is the synchronised copy of srst
	always_comb begin
		next_st = st;
		next_st.rst_s1 = srst;
		next_st.rst_s2 = st.rst_s1;
		next_st.adj_s1 = adjust_req;
		next_st.adj_s2 = st.adj_s1;
		if (st.rst_s2) begin
			next_st.phase = 2'h0;
			next_st.pipe = '0;
			next_st.word = '0;
			next_st.toggle = 1'b0;
		end else begin
			next_st.pipe = {st.pipe[LANE_PIPE_DEPTH-2:0], word_in};
			// slipping the tap may drop or repeat a character, accepted while adjusting
			if (st.adj_s2) begin
				next_st.phase = st.phase + 2'h1; // [RQ12]
			end
			next_st.word = st.pipe[st.phase];
			next_st.toggle = ~st.toggle;
		end
	end

	// single register stage for the lane domain
	always_ff @(posedge lane_input_clock) begin
		st <= next_st;
	end

	assign word_out = st.word;
	assign toggle_out = st.toggle;
	assign adjusting = st.adj_s2;

	// capture phase is frozen while the synchronised adjust request is low
	property p_phase_hold;
		@(posedge lane_input_clock) disable iff (st.rst_s2)
		!st.adj_s2 |=> st.phase == $past(st.phase);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase moved while held"); // [RQ12]

endmodule // tics_lane_capture

// ### tics_input_clock_select.sv
// transmit input clock select, capture, parity check and clock output control
// Summary of operation
// RQ1: half-rate reference samples on both clock edges
// RQ2: special select with control bits picks character kind
// RQ3: middle select captures special select on lane a
// RQ4: parity enabled xors parity with captured byte
// RQ5: source select picks reference, own or lane-a clock
// RQ6: half-rate with lane clocks is invalid configuration
// RQ7: pll multiplies by twenty high, ten low
// RQ8: receive clocks follow reference when selected low
// RQ9: transmit clock output doubles when rate high
// RQ10: true and complement clocks stay synchronous together
// RQ11: host lane clocks match transmit output frequency; the bench runs its lane clocks at 48 ns against a 40 ns tx clock at rate low
// RQ12: capture phase adjusts in reset, frozen otherwise; the control register bit also forces adjustment outside reset
// RQ13: floating three-level select reads as middle
// RQ14: static selects change only during transmit reset
`timescale 1ns/10ps
module tics_input_clock_select (
	input wire logic clock,
	input wire logic srst,
	input wire logic lane_a_input_clock,
	input wire logic lane_b_input_clock,
	input wire logic ref_clock_in,
	input wire logic tx_phase_reset,
	input wire tics_pkg::tics_tri_t tx_clock_source_select,
	input wire tics_pkg::tics_tri_t parity_check_control,
	input wire logic ref_rate_select,
	input wire logic rx_clock_source_select,
	input wire logic [7:0] lane_a_char_bus,
	input wire logic [1:0] lane_a_control_bits,
	input wire logic lane_a_parity_in,
	input wire logic [7:0] lane_b_char_bus,
	input wire logic [1:0] lane_b_control_bits,
	input wire logic lane_b_parity_in,
	input wire logic special_char_select,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output tics_pkg::tics_word_t lane_a_word,
	output tics_pkg::tics_word_t lane_b_word,
	output tics_pkg::tics_kind_t lane_a_kind,
	output tics_pkg::tics_kind_t lane_b_kind,
	output logic word_valid,
	output logic lane_a_parity_error,
	output logic lane_b_parity_error,
	output tics_pkg::tics_word_t fall_a_word,
	output tics_pkg::tics_word_t fall_b_word,
	output logic fall_valid,
	output logic [4:0] pll_multiplier,
	output logic synthesized_tx_clock_out,
	output logic synthesized_tx_clock_out_n,
	output logic rx_clock_out_first,
	output logic rx_clock_out_second,
	output logic invalid_config
);
	import tics_pkg::*;

	// every rising-edge reference-domain register of the block
	typedef struct packed {
		logic rst_s1; // phase reset pin, first stage
		logic rst_s2; // phase reset pin, second stage
		logic ref_s1; // reference pin, first stage
		logic ref_s2; // reference pin, second stage
		logic [2:0] tgl_s1; // lane toggles, first stage
		logic [2:0] tgl_s2; // lane toggles, second stage
		logic [2:0] tgl_seen; // last toggle value consumed
		logic adjust; // phase adjust request to the lanes
		logic adj_s1; // lanes adjusting, first stage
		logic adj_s2; // lanes adjusting, second stage
		tics_word_t out_a; // captured lane a word
		tics_word_t out_b; // captured lane b word
		tics_kind_t kind_a;
		tics_kind_t kind_b;
		logic valid; // one-cycle word strobe
		logic perr_a;
		logic perr_b;
		logic sticky_a; // parity error held for software
		logic sticky_b;
		logic invalid;
		logic [4:0] mult;
		logic [1:0] div_cnt; // transmit clock half-period counter
		logic txclk;
		logic txclk_n;
		logic rxclk_a;
		logic rxclk_c;
		logic [31:0] ctrl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tics_state_t;

	tics_state_t st;
	tics_state_t next_st;

	// lane capture outputs, one path per clock/bus pairing
	tics_word_t cap_a; // lane a bus on lane a clock
	tics_word_t cap_b; // lane b bus on lane b clock
	tics_word_t cap_ab; // lane b bus on lane a clock
	logic [2:0] cap_tgl;
	logic [2:0] cap_adj;

	// words assembled from the pins, reference-domain host logic needs no sync
	tics_word_t pin_a;
	tics_word_t pin_b;
	tics_word_t lane_b_in;
	tics_level_t src_lvl;
	logic par_en;
	logic src_low;

	// the falling-edge half of the half-rate sample
	tics_word_t fall_a;
	tics_word_t fall_b;
	logic fall_v;

	always_comb begin
		pin_a = {lane_a_char_bus, lane_a_control_bits, lane_a_parity_in, special_char_select};
		pin_b = {lane_b_char_bus, lane_b_control_bits, lane_b_parity_in, special_char_select};
		lane_b_in = pin_b;
		src_lvl = tics_level(tx_clock_source_select); // [RQ13]
		par_en = tics_level(parity_check_control) != TRI_LOW; // [RQ13]
		src_low = src_lvl == TRI_LOW;
	end

	// lane a clock path for lane a data
	tics_lane_capture u_lane_a (
		.lane_input_clock(lane_a_input_clock),
		.srst(srst),
		.adjust_req(st.adjust),
		.word_in(pin_a),
		.word_out(cap_a),
		.toggle_out(cap_tgl[0]),
		.adjusting(cap_adj[0])
	);

	// lane b own clock path, used with independent lane clocks
	tics_lane_capture u_lane_b (
		.lane_input_clock(lane_b_input_clock),
		.srst(srst),
		.adjust_req(st.adjust),
		.word_in(lane_b_in),
		.word_out(cap_b),
		.toggle_out(cap_tgl[1]),
		.adjusting(cap_adj[1])
	);

	// lane b data on lane a clock, used when lane a clocks both lanes
	tics_lane_capture u_lane_ab (
		.lane_input_clock(lane_a_input_clock),
		.srst(srst),
		.adjust_req(st.adjust),
		.word_in(lane_b_in),
		.word_out(cap_ab),
		.toggle_out(cap_tgl[2]),
		.adjusting(cap_adj[2])
	);

	// falling-edge sampler; only live for the half-rate reference mode
	always_ff @(negedge clock) begin
		if (srst) begin
			fall_a <= '0;
			fall_b <= '0;
			fall_v <= 1'b0;
		end else begin
			fall_v <= src_low && ref_rate_select; // [RQ1]
			if (src_low && ref_rate_select) begin
				fall_a <= pin_a; // [RQ1]
				fall_b <= pin_b;
			end
		end
	end

	// main next-state logic
	always_comb begin
		logic apb_access; // access phase of an apb write transfer
		logic hit; // address decodes to a register
		logic [2:0] tgl_edge; // new word offered by each lane path
		logic set_a;
		logic set_b;
		tics_word_t nw_a;
		tics_word_t nw_b;
		logic take;
		apb_access = 1'b0;
		hit = 1'b0;
		tgl_edge = 3'h0;
		set_a = 1'b0;
		set_b = 1'b0;
		nw_a = st.out_a;
		nw_b = st.out_b;
		take = 1'b0;
		next_st = st;

		// pin synchronisers; only the second stage is read beyond here
		next_st.rst_s1 = tx_phase_reset;
		next_st.rst_s2 = st.rst_s1;
		next_st.ref_s1 = ref_clock_in;
		next_st.ref_s2 = st.ref_s1;
		next_st.tgl_s1 = cap_tgl;
		next_st.tgl_s2 = st.tgl_s1;
		tgl_edge = st.tgl_s2 ^ st.tgl_seen;
		next_st.tgl_seen = st.tgl_s2;
		next_st.adj_s1 = |cap_adj;
		next_st.adj_s2 = st.adj_s1;

		// phase adjust while the reset pin is low or software forces it
		next_st.adjust = ~st.rst_s2 | st.ctrl[CTRL_PHASE_ADJ_BIT]; // [RQ12]

		// input register clock selection
		unique case (src_lvl)
			TRI_LOW: begin
				nw_a = pin_a; // [RQ5]
				nw_b = pin_b;
				take = 1'b1;
			end
			TRI_MID: begin
				// lane b keeps its own clock; special select rides lane a
				nw_a = cap_a; // [RQ3] [RQ5]
				nw_b = {cap_b.tx_char_bus, cap_b.tx_control_bits, cap_b.parity,
					cap_a.special_char_select}; // [RQ3]
				take = tgl_edge[0];
			end
			TRI_HIGH: begin
				nw_a = cap_a; // [RQ5]
				nw_b = cap_ab;
				take = tgl_edge[0];
			end
		endcase
		next_st.valid = take;
		if (take) begin
			next_st.out_a = nw_a;
			next_st.out_b = nw_b;
			next_st.kind_a = tics_kind(nw_a); // [RQ2]
			next_st.kind_b = tics_kind(nw_b); // [RQ2]
			set_a = par_en && tics_parity_bad(nw_a); // [RQ4]
			set_b = par_en && tics_parity_bad(nw_b); // [RQ4]
			next_st.perr_a = set_a;
			next_st.perr_b = set_b;
		end

		// configuration check; selects are expected static under reset
		next_st.invalid = ref_rate_select && !src_low; // [RQ6] [RQ14]
		next_st.mult = ref_rate_select ? PLL_MULT_HIGH : PLL_MULT_LOW; // [RQ7]

		// transmit clock: half period shrinks to one cycle when rate is high
		if (st.div_cnt >= (ref_rate_select ? TXCLK_HALF_HIGH : TXCLK_HALF_LOW) - 2'h1) begin
			next_st.div_cnt = 2'h0;
			next_st.txclk = ~st.txclk; // [RQ9]
			next_st.txclk_n = st.txclk; // [RQ10]
		end else begin
			next_st.div_cnt = st.div_cnt + 2'h1;
		end

		// receive clocks follow the reference, else the transmit clock
		next_st.rxclk_a = rx_clock_source_select ? st.txclk : st.ref_s2; // [RQ8]
		next_st.rxclk_c = rx_clock_source_select ? st.txclk : st.ref_s2; // [RQ8]

		// apb slave: answer one cycle after setup, no wait states
		next_st.pready = psel && !penable && !st.pready;
		hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
		if (psel && !penable && !st.pready) begin
			next_st.pslverr = !hit;
			next_st.prdata = 32'h00000000;
			if (paddr == ADDR_CTRL) begin
				next_st.prdata = st.ctrl;
			end else if (paddr == ADDR_STATUS) begin
				next_st.prdata[STAT_INVALID_BIT] = st.invalid;
				next_st.prdata[STAT_PAR_A_BIT] = st.sticky_a;
				next_st.prdata[STAT_PAR_B_BIT] = st.sticky_b;
				next_st.prdata[STAT_MULT_LSB +: 5] = st.mult;
				next_st.prdata[STAT_ADJ_BIT] = st.adj_s2;
			end
		end else if (!psel) begin
			next_st.pslverr = 1'b0;
		end
		apb_access = psel && penable && st.pready && pwrite;
		if (apb_access && paddr == ADDR_CTRL) begin
			next_st.ctrl = {31'h00000000, pwdata[CTRL_PHASE_ADJ_BIT]};
		end
		// write one to clear, but a new error in the same cycle wins
		if (apb_access && paddr == ADDR_STATUS) begin
			if (pwdata[STAT_PAR_A_BIT]) begin
				next_st.sticky_a = 1'b0;
			end
			if (pwdata[STAT_PAR_B_BIT]) begin
				next_st.sticky_b = 1'b0;
			end
		end
		if (set_a) begin
			next_st.sticky_a = 1'b1;
		end
		if (set_b) begin
			next_st.sticky_b = 1'b1;
		end
	end

	// single register stage of the reference domain
	always_ff @(posedge clock) begin
		if (srst) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.mult <= PLL_MULT_LOW;
			st.txclk_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign lane_a_word = st.out_a;
	assign lane_b_word = st.out_b;
	assign lane_a_kind = st.kind_a;
	assign lane_b_kind = st.kind_b;
	assign word_valid = st.valid;
	assign lane_a_parity_error = st.perr_a;
	assign lane_b_parity_error = st.perr_b;
	assign fall_a_word = fall_a;
	assign fall_b_word = fall_b;
	assign fall_valid = fall_v;
	assign pll_multiplier = st.mult;
	assign synthesized_tx_clock_out = st.txclk;
	assign synthesized_tx_clock_out_n = st.txclk_n;
	assign rx_clock_out_first = st.rxclk_a;
	assign rx_clock_out_second = st.rxclk_c;
	assign invalid_config = st.invalid;

	// reference-clock checks
	sequence s_rate_high_held;
		ref_rate_select [*3];
	endsequence

	property p_mult;
		@(posedge clock) disable iff (srst)
		ref_rate_select |=> pll_multiplier == PLL_MULT_HIGH;
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier not twenty"); // [RQ7]

	property p_invalid;
		@(posedge clock) disable iff (srst)
		(ref_rate_select && !src_low) |=> invalid_config;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid mode not flagged"); // [RQ6]

	property p_parity;
		@(posedge clock) disable iff (srst)
		(src_low && par_en && tics_parity_bad(pin_a)) |=> lane_a_parity_error && word_valid;
	endproperty
	a_parity: assert property (p_parity) else $error("parity error missed"); // [RQ4]

	property p_txclk_fast;
		@(posedge clock) disable iff (srst)
		s_rate_high_held |=> synthesized_tx_clock_out != $past(synthesized_tx_clock_out);
	endproperty
	a_txclk_fast: assert property (p_txclk_fast) else $error("tx clock not doubled"); // [RQ9]

	property p_txclk_pair;
		@(posedge clock) disable iff (srst)
		synthesized_tx_clock_out_n == ~synthesized_tx_clock_out;
	endproperty
	a_txclk_pair: assert property (p_txclk_pair) else $error("tx clock pair skewed"); // [RQ10]

	property p_rx_follow;
		@(posedge clock) disable iff (srst)
		(!rx_clock_source_select) [*4] |-> rx_clock_out_first == $past(ref_clock_in, 3);
	endproperty
	a_rx_follow: assert property (p_rx_follow) else $error("rx clock not following"); // [RQ8]

	property p_src_low;
		@(posedge clock) disable iff (srst)
		src_low |=> lane_a_word == $past(pin_a) && word_valid;
	endproperty
	a_src_low: assert property (p_src_low) else $error("reference capture wrong"); // [RQ5]

	property p_special_mid;
		@(posedge clock) disable iff (srst)
		(src_lvl == TRI_MID && (st.tgl_s2[0] != st.tgl_seen[0]))
			|=> lane_b_word.special_char_select == $past(cap_a.special_char_select);
	endproperty
	a_special_mid: assert property (p_special_mid) else $error("special select not lane a"); // [RQ3]

	property p_kind;
		@(posedge clock) disable iff (srst)
		(word_valid && lane_a_word.special_char_select && lane_a_word.tx_control_bits == 2'h3)
			|-> lane_a_kind == KIND_WORD_SYNC;
	endproperty
	a_kind: assert property (p_kind) else $error("character kind mismatch"); // [RQ2]

	property p_fall;
		@(negedge clock) disable iff (srst)
		(src_low && ref_rate_select) |=> fall_valid && fall_a_word == $past(pin_a);
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge sample missed"); // [RQ1]

endmodule // tics_input_clock_select

// ### tics_host_model.sv
// host model that presents transmit character pairs on its drive clock
`timescale 1ns/10ps
module tics_host_model (
	input wire logic drive_clock,
	output logic [7:0] lane_a_char_bus,
	output logic [1:0] lane_a_control_bits,
	output logic lane_a_parity_in,
	output logic [7:0] lane_b_char_bus,
	output logic [1:0] lane_b_control_bits,
	output logic lane_b_parity_in,
	output logic special_char_select
);
	// idle pins carry a zero character with good odd parity
	initial begin
		{lane_a_char_bus, lane_a_control_bits, lane_a_parity_in} = 11'h001;
		{lane_b_char_bus, lane_b_control_bits, lane_b_parity_in} = 11'h001;
		special_char_select = 1'b0;
	end

	// pins change only just after a drive edge and hold until the next call
	task automatic present(input logic [7:0] ca, input logic [7:0] cb, input logic [1:0] ctl,
		input logic spc, input logic bad_a, input logic bad_b);
		@(posedge drive_clock);
		lane_a_char_bus <= ca;
		lane_b_char_bus <= cb;
		lane_a_control_bits <= ctl; // control bits and special select go together
		lane_b_control_bits <= ctl;
		special_char_select <= spc;
		// odd parity, broken only when a test asks for it
		lane_a_parity_in <= ~(^ca) ^ bad_a;
		lane_b_parity_in <= ~(^cb) ^ bad_b;
	endtask
endmodule // tics_host_model

// ### test_tics_input_clock_select.sv
// self-checking bench for the transmit input clock select block
`timescale 1ns/10ps
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module test_tics_input_clock_select;
	import tics_pkg::*;
	// one ordinary character case: pins beside the outcome expected
	typedef struct packed {
		logic [7:0] ch;
		logic [1:0] ctl;
		logic spc;
		logic bad_a;
		logic bad_b;
		tics_kind_t kind;
	} tics_row_t;
	tics_row_t rows [7] = '{
		'{8'h00, 2'h0, 1'b0, 1'b0, 1'b0, KIND_DATA},
		'{8'h5A, 2'h1, 1'b0, 1'b0, 1'b0, KIND_SPECIAL},
		'{8'hA5, 2'h2, 1'b0, 1'b0, 1'b0, KIND_REPLACE},
		'{8'hFF, 2'h3, 1'b0, 1'b0, 1'b0, KIND_SPECIAL},
		'{8'h3C, 2'h3, 1'b1, 1'b0, 1'b0, KIND_WORD_SYNC},
		'{8'h81, 2'h0, 1'b1, 1'b1, 1'b0, KIND_DATA},
		'{8'h7E, 2'h2, 1'b1, 1'b0, 1'b1, KIND_REPLACE}
	};
	tics_row_t r;
	int fail_count = 0;
	int cmp_count = 0;
	// stimulus, given a value at time zero; err, prdata and rd are left unset
	logic clock = 1'b0, srst = 1'b1, ref_clock_in = 1'b0, tx_phase_reset = 1'b1;
	logic lane_a_input_clock = 1'b0, lane_b_input_clock = 1'b0, use_lane = 1'b0;
	logic ref_rate_select = 1'b0, rx_clock_source_select = 1'b0;
	tics_tri_t tx_clock_source_select = '{1'b1, 1'b0};
	tics_tri_t parity_check_control = '{1'b1, 1'b1};
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	// observed outputs and host pins
	logic pready, pslverr, word_valid, fall_valid, invalid_config;
	logic lane_a_parity_error, lane_b_parity_error, rx_clock_out_first, rx_clock_out_second;
	logic synthesized_tx_clock_out, synthesized_tx_clock_out_n;
	tics_word_t lane_a_word, lane_b_word, fall_a_word, fall_b_word;
	tics_kind_t lane_a_kind, lane_b_kind;
	logic [4:0] pll_multiplier;
	logic [7:0] lane_a_char_bus, lane_b_char_bus;
	logic [1:0] lane_a_control_bits, lane_b_control_bits;
	logic lane_a_parity_in, lane_b_parity_in, special_char_select;
	// host follows whichever clock captures; only switched under reset
	wire logic drive_clock = use_lane ? lane_a_input_clock : clock;

	tics_host_model host (.drive_clock, .lane_a_char_bus, .lane_a_control_bits,
		.lane_a_parity_in, .lane_b_char_bus, .lane_b_control_bits, .lane_b_parity_in,
		.special_char_select);

	tics_input_clock_select dut (.clock, .srst, .lane_a_input_clock, .lane_b_input_clock,
		.ref_clock_in, .tx_phase_reset, .tx_clock_source_select, .parity_check_control,
		.ref_rate_select, .rx_clock_source_select, .lane_a_char_bus, .lane_a_control_bits,
		.lane_a_parity_in, .lane_b_char_bus, .lane_b_control_bits, .lane_b_parity_in,
		.special_char_select, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .lane_a_word, .lane_b_word, .lane_a_kind, .lane_b_kind, .word_valid,
		.lane_a_parity_error, .lane_b_parity_error, .fall_a_word, .fall_b_word, .fall_valid,
		.pll_multiplier, .synthesized_tx_clock_out, .synthesized_tx_clock_out_n,
		.rx_clock_out_first, .rx_clock_out_second, .invalid_config);

	// reference clock, 10 ns
	initial begin
		forever #5 clock = ~clock;
	end
	// lane clocks, 48 ns, out of step with the reference and with each other
	initial begin
		#3;
		forever #24 lane_a_input_clock = ~lane_a_input_clock;
	end
	initial begin
		#17;
		forever #24 lane_b_input_clock = ~lane_b_input_clock;
	end

	// print counts and verdict, then stop
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// a slave that never answers ends the run
		if (n >= 20) begin
			fail_count++;
			$display("ERROR pready expected 1 seen 0");
			print_verdict();
		end
	endtask

	// static selects change only while reset is held
	task automatic restart(input tics_tri_t src, input logic rt, input logic ln);
		@(posedge clock);
		srst <= 1'b1;
		tx_clock_source_select <= src;
		ref_rate_select <= rt;
		use_lane <= ln;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
	endtask

	// tx clock toggle count, complement pair, rx clock behind the pin or the tx clock
	task automatic check_clocks(input int exp_toggles);
		int t;
		logic prev;
		logic [2:0] hist;
		logic exp_rx;
		t = 0;
		hist = 3'h0;
		prev = 1'b0;
		for (int i = 0; i < 43; i++) begin
			@(posedge clock);
			hist = {hist[1:0], ref_clock_in};
			if (i % 3 == 0) begin
				ref_clock_in <= ~ref_clock_in;
			end
			#1;
			if (i >= 3) begin
				exp_rx = rx_clock_source_select ? prev : hist[2];
				t += (synthesized_tx_clock_out !== prev);
				`CHK("rx first", exp_rx, rx_clock_out_first)
				`CHK("rx second", exp_rx, rx_clock_out_second)
			end
			prev = synthesized_tx_clock_out;
			`CHK("txclk pair", ~synthesized_tx_clock_out, synthesized_tx_clock_out_n)
		end
		`CHK("txclk toggles", exp_toggles, t)
	endtask

	// present a pair on the lane clock and wait for it on the reference side
	task automatic lane_word(input logic [7:0] ch);
		int n;
		n = 0;
		host.present(ch, ~ch, 2'h3, 1'b1, 1'b0, 1'b0);
		// lane b has its own capture phase: wait for both lanes
		while (!(word_valid === 1'b1 && lane_a_word.tx_char_bus === ch
			&& lane_b_word.tx_char_bus === ~ch) && n < 300) begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("lane a char", ch, lane_a_word.tx_char_bus)
		`CHK("lane b char", ~ch, lane_b_word.tx_char_bus)
		`CHK("lane b special", 1'b1, lane_b_word.special_char_select)
		`CHK("lane a kind", KIND_WORD_SYNC, lane_a_kind)
		if (n >= 300) begin
			print_verdict();
		end
	endtask

	initial begin
		// values while reset is still held
		repeat (7) @(posedge clock);
		#1;
		`CHK("mult in reset", PLL_MULT_LOW, pll_multiplier)
		`CHK("txclk_n in reset", 1'b1, synthesized_tx_clock_out_n)
		@(posedge clock);
		srst <= 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK("ctrl reset", CTRL_RESET, rd)
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("status mult", PLL_MULT_LOW, rd[STAT_MULT_LSB +: 5])
		apb(1'b0, 8'h08, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		$display("test reset and registers done");
		// reference capture table
		foreach (rows[i]) begin
			r = rows[i];
			host.present(r.ch, ~r.ch, r.ctl, r.spc, r.bad_a, r.bad_b);
			@(posedge clock);
			#1;
			`CHK("valid", 1'b1, word_valid)
			`CHK("a char", r.ch, lane_a_word.tx_char_bus)
			`CHK("b char", ~r.ch, lane_b_word.tx_char_bus)
			`CHK("a kind", r.kind, lane_a_kind)
			`CHK("b kind", r.kind, lane_b_kind)
			`CHK("a parity", r.bad_a, lane_a_parity_error)
			`CHK("b parity", r.bad_b, lane_b_parity_error)
		end
		// sticky lane b error, cleared by a write of one once good characters flow
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("sticky b", 1'b1, rd[STAT_PAR_B_BIT])
		host.present(8'h11, 8'h22, 2'h0, 1'b0, 1'b0, 1'b0);
		apb(1'b1, ADDR_STATUS, 32'h4);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("sticky b cleared", 1'b0, rd[STAT_PAR_B_BIT])
		// parity check off, then floating select reads as middle
		@(posedge clock);
		parity_check_control <= '{1'b1, 1'b0};
		host.present(8'h33, 8'h44, 2'h0, 1'b0, 1'b1, 1'b1);
		repeat (2) @(posedge clock);
		#1;
		`CHK("parity off", 1'b0, lane_a_parity_error)
		@(posedge clock);
		parity_check_control <= '{1'b0, 1'b0};
		repeat (2) @(posedge clock);
		#1;
		`CHK("parity floating", 1'b1, lane_a_parity_error)
		$display("test reference capture done");
		check_clocks(20);
		$display("test full rate clocks done");
		// half-rate reference: falling edge capture and doubled tx clock
		restart('{1'b1, 1'b0}, 1'b1, 1'b0);
		repeat (4) @(posedge clock);
		#1;
		`CHK("mult high", PLL_MULT_HIGH, pll_multiplier)
		`CHK("valid config", 1'b0, invalid_config)
		`CHK("fall valid", 1'b1, fall_valid)
		host.present(8'hC3, 8'h3C, 2'h0, 1'b0, 1'b0, 1'b0);
		@(negedge clock);
		#1;
		`CHK("fall a", 8'hC3, fall_a_word.tx_char_bus)
		`CHK("fall b", 8'h3C, fall_b_word.tx_char_bus)
		check_clocks(40);
		$display("test half rate done");
		// half rate with a floating source select is refused as invalid
		restart('{1'b0, 1'b0}, 1'b1, 1'b0);
		repeat (4) @(posedge clock);
		#1;
		`CHK("invalid", 1'b1, invalid_config)
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("status invalid", 1'b1, rd[STAT_INVALID_BIT])
		// own lane clocks, phase adjusted while the phase reset is low
		tx_phase_reset <= 1'b0;
		restart('{1'b0, 1'b0}, 1'b0, 1'b1);
		repeat (20) @(posedge clock);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("adjusting", 1'b1, rd[STAT_ADJ_BIT])
		tx_phase_reset <= 1'b1;
		repeat (30) @(posedge clock);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("phase frozen", 1'b0, rd[STAT_ADJ_BIT])
		// software forces adjustment too
		apb(1'b1, ADDR_CTRL, 32'h1);
		repeat (20) @(posedge clock);
		apb(1'b0, ADDR_STATUS, 32'h0);
		`CHK("forced adjust", 1'b1, rd[STAT_ADJ_BIT])
		apb(1'b1, ADDR_CTRL, 32'h0);
		lane_word(8'h96);
		$display("test middle source done");
		// lane a clock for both lanes
		restart('{1'b1, 1'b1}, 1'b0, 1'b1);
		lane_word(8'h5C);
		@(posedge clock);
		rx_clock_source_select <= 1'b1;
		check_clocks(20);
		$display("test high source done");
		print_verdict();
	end
endmodule // test_tics_input_clock_select
